// *** rtl/usu_pkg.sv ***
// shared constants and types of the async serial unit register block
package usu_pkg;
  // register window bases, as word indexes; the offset is the low byte of the index
  localparam logic [9:0] USU_BASE_BLOCKING = 10'h200;
  localparam logic [9:0] USU_BASE_NONBLOCKING = 10'h300;
  // register offsets (word indexes inside a window)
  localparam logic [7:0] USU_OFS_STATUS = 8'h44;
  localparam logic [7:0] USU_OFS_CONFIG = 8'h45;
  localparam logic [7:0] USU_OFS_EXT_CTRL = 8'h46;
  localparam logic [7:0] USU_OFS_DATA = 8'h47;
  localparam logic [7:0] USU_OFS_EVENT = 8'h48;
  localparam logic [7:0] USU_OFS_MASK = 8'h49;
  // extended_control field positions
  localparam int USU_EXT_RX_NINTH = 7;
  localparam int USU_EXT_TX_NINTH = 6;
  localparam int USU_EXT_PIN_DIR = 5;
  localparam int USU_EXT_TX_INV = 4;
  localparam int USU_EXT_OVERRUN_IE = 3;
  localparam int USU_EXT_NOISE_IE = 2;
  localparam int USU_EXT_FRAMING_IE = 1;
  localparam int USU_EXT_PARITY_IE = 0;
  // configuration field positions
  localparam int USU_CFG_NINE_BIT = 0;
  localparam int USU_CFG_LOOP = 1;
  localparam int USU_CFG_RX_SOURCE = 2;
  localparam int USU_CFG_PARITY_EN = 3;
  localparam int USU_CFG_PARITY_ODD = 4;
  // serial status field positions (error flags sit on the enable positions)
  localparam int USU_STAT_TX_EMPTY = 7;
  localparam int USU_STAT_RX_FULL = 5;
  // event / mask field positions
  localparam int USU_EVT_TX_EMPTY = 5;
  localparam int USU_EVT_RX_FULL = 4;
  // values after reset
  localparam logic [7:0] USU_EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] USU_DATA_RST = 8'h00;
  localparam logic [7:0] USU_CONFIG_RST = 8'h00;
  localparam logic [5:0] USU_MASK_RST = 6'h00;
  // device clock cycles per serial bit
  localparam int USU_BIT_CYCLES = 16;
  // the four receive error flags, also the order of their enables
  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } usu_err_t;
  // receiver sequence, gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    USU_RX_IDLE = 2'b00,
    USU_RX_START = 2'b01,
    USU_RX_DATA = 2'b11,
    USU_RX_STOP = 2'b10
  } usu_rx_state_t;
endpackage

// *** rtl/usu_tx_shift.sv ***
// transmit shifter: frames one 8- or 9-bit character, lsb first
module usu_tx_shift import usu_pkg::*; #(
  parameter int BIT_CYCLES = USU_BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [8:0] data_i,
  input wire logic nine_bit_i,
  output logic busy_o,
  output logic line_o
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] LAST_CYC = CW'(BIT_CYCLES - 1);

  logic [10:0] shift_ff;
  logic [3:0] bits_left_ff;
  logic [CW-1:0] cyc_ff;
  logic busy_ff;
  logic line_ff;

  // frame: start 0, data lsb first, stop 1; unused top bit is never shifted out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_ff <= 11'h7ff;
      bits_left_ff <= 4'h0;
      cyc_ff <= '0;
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
    end else if (!busy_ff) begin
      line_ff <= 1'b1;
      if (load_i) begin
        shift_ff <= nine_bit_i ? {1'b1, data_i, 1'b0} : {2'b11, data_i[7:0], 1'b0};
        bits_left_ff <= nine_bit_i ? 4'hb : 4'ha;
        cyc_ff <= '0;
        busy_ff <= 1'b1;
        line_ff <= 1'b0;
      end
    end else if (cyc_ff == LAST_CYC) begin
      cyc_ff <= '0;
      shift_ff <= {1'b1, shift_ff[10:1]};
      bits_left_ff <= bits_left_ff - 4'h1;
      busy_ff <= (bits_left_ff != 4'h1);
      line_ff <= (bits_left_ff == 4'h1) ? 1'b1 : shift_ff[1];
    end else begin
      cyc_ff <= cyc_ff + 1'b1;
    end
  end

  assign busy_o = busy_ff;
  assign line_o = line_ff;
endmodule // usu_tx_shift

// *** rtl/usu_regs.sv ***
// async serial unit: ninth bits, pin control, error interrupt enables, data buffer
// What this block does
// RULE1 - nine-bit mode: received ninth bit reads at extended control bit 7
// RULE2 - software reads the ninth bit before the data register
// RULE3 - nine-bit mode: extended control bit 6 is the ninth transmit bit
// RULE4 - nine-bit mode: data write sends all nine bits; stored ninth bit is reused
// RULE5 - single-wire mode: bit 5 set drives transmit pin, clear makes it input
// RULE6 - bit 4 inverts everything driven on the transmit line
// RULE7 - bit 3 lets the overrun flag raise the error interrupt
// RULE8 - bit 2 lets the noise flag raise the error interrupt
// RULE9 - bit 1 lets the framing flag raise the error interrupt
// RULE10 - bit 0 lets the parity flag raise the error interrupt
// RULE11 - data register reads receive buffer, writes transmit buffer
// RULE12 - data register read finishes the automatic flag clearing
// RULE13 - decode at bases 0x200 and 0x300; data at offset 0x47 resets zero
// RULE14 - zero sampled at stop bit sets framing flag with receive full
// RULE15 - frame is start 0, eight or nine data bits lsb first, stop 1
// RULE16 - error interrupt is OR of enabled error flags
module usu_regs import usu_pkg::*; #(
  parameter int BIT_CYCLES = USU_BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave, 32-bit data, byte address
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial lines
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_o,
  // interrupts
  output logic irq_o,
  output logic err_irq_o
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] LAST_CYC = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] MID_CYC = CW'(BIT_CYCLES / 2);

  // bus side
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic acc;
  logic hit;
  logic wr_lane0;
  logic [7:0] ofs;
  logic rd_status;
  logic rd_data;
  logic wr_data;
  logic rd_event;

  // registers
  logic [7:0] ext_ff;
  logic [7:0] cfg_ff;
  logic [5:0] mask_ff;
  logic [5:0] event_ff;
  logic [7:0] rx_buf_ff;
  logic rx_ninth_ff;
  logic rx_full_ff;
  logic tx_empty_ff;
  logic [8:0] tx_buf_ff;
  logic tx_pend_ff;
  usu_err_t err_ff;
  logic armed_ff;

  // line side
  logic txd_ff;
  logic txd_oe_ff;
  logic irq_ff;
  logic err_irq_ff;
  logic tx_busy;
  logic tx_line;
  logic tx_load;
  logic rx_line;
  logic single_wire;

  // receiver
  usu_rx_state_t rx_state_ff;
  usu_rx_state_t nxt_rx_state;
  logic [CW-1:0] rx_cyc_ff;
  logic [3:0] rx_bits_ff;
  logic [8:0] rx_shift_ff;
  logic [2:0] rx_samp_ff;
  logic rx_noise_ff;
  logic rx_eval;
  logic rx_vote;
  logic rx_done;
  logic rx_fe;
  logic rx_pe;
  logic rx_lost;
  logic [8:0] rx_word;
  logic [7:0] stat_rd;

  // address decode: both windows reach the same registers
  assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
  assign hit = (wb_adr_i[11:10] == USU_BASE_BLOCKING[9:8]) ||
               (wb_adr_i[11:10] == USU_BASE_NONBLOCKING[9:8]); // [RULE13]
  assign ofs = wb_adr_i[9:2];
  assign wr_lane0 = acc && hit && wb_we_i && wb_sel_i[0];
  assign rd_status = acc && hit && !wb_we_i && (ofs == USU_OFS_STATUS);
  assign rd_data = acc && hit && !wb_we_i && (ofs == USU_OFS_DATA); // [RULE11]
  assign wr_data = wr_lane0 && (ofs == USU_OFS_DATA); // [RULE11]
  assign rd_event = acc && hit && !wb_we_i && (ofs == USU_OFS_EVENT);

  // serial status image; error flags share the enable bit positions
  assign stat_rd = {tx_empty_ff, 1'b0, rx_full_ff, 1'b0, err_ff};

  // one wait state: ack and read data rise together, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= acc;
      rdat_ff <= 32'h0000_0000;
      if (acc && hit && !wb_we_i) begin
        case (ofs)
          USU_OFS_STATUS: rdat_ff[7:0] <= stat_rd;
          USU_OFS_CONFIG: rdat_ff[7:0] <= cfg_ff;
          USU_OFS_EXT_CTRL: rdat_ff[7:0] <= {rx_ninth_ff, ext_ff[6:0]}; // [RULE1]
          USU_OFS_DATA: rdat_ff[7:0] <= rx_buf_ff; // [RULE11]
          USU_OFS_EVENT: rdat_ff[5:0] <= event_ff;
          USU_OFS_MASK: rdat_ff[5:0] <= mask_ff;
          default: rdat_ff <= 32'h0000_0000; // unmapped reads zero, still acked
        endcase
      end
    end
  end

  // software controls; bit 7 of extended control is hardware owned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_ff <= USU_EXT_CTRL_RST;
      cfg_ff <= USU_CONFIG_RST;
      mask_ff <= USU_MASK_RST;
    end else if (wr_lane0) begin
      if (ofs == USU_OFS_EXT_CTRL) begin
        ext_ff <= {1'b0, wb_dat_i[6:0]}; // ninth tx bit held until rewritten [RULE3]
      end
      if (ofs == USU_OFS_CONFIG) begin
        cfg_ff <= {3'h0, wb_dat_i[4:0]};
      end
      if (ofs == USU_OFS_MASK) begin
        mask_ff <= wb_dat_i[5:0];
      end
    end
  end

  // transmit buffer: data write captures byte plus the stored ninth bit
  assign tx_load = tx_pend_ff && !tx_busy;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf_ff <= {1'b0, USU_DATA_RST};
      tx_pend_ff <= 1'b0;
      tx_empty_ff <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_pend_ff <= 1'b0;
        tx_empty_ff <= 1'b1;
      end
      if (wr_data) begin
        tx_buf_ff <= {ext_ff[USU_EXT_TX_NINTH], wb_dat_i[7:0]}; // [RULE3] [RULE4]
        tx_pend_ff <= 1'b1;
        tx_empty_ff <= 1'b0;
      end
    end
  end

  // whole nine-bit value goes to the shifter in one step
  usu_tx_shift #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tx_load),
    .data_i(tx_buf_ff), // [RULE4]
    .nine_bit_i(cfg_ff[USU_CFG_NINE_BIT]),
    .busy_o(tx_busy),
    .line_o(tx_line)
  );

  // pin drive: inversion covers start, data, stop and idle alike
  assign single_wire = cfg_ff[USU_CFG_LOOP] && cfg_ff[USU_CFG_RX_SOURCE];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_ff <= 1'b1;
      txd_oe_ff <= 1'b1;
    end else begin
      txd_ff <= tx_line ^ ext_ff[USU_EXT_TX_INV]; // [RULE6]
      txd_oe_ff <= single_wire ? ext_ff[USU_EXT_PIN_DIR] : 1'b1; // [RULE5]
    end
  end

  // receive source: own pin, internal loop, or the shared transmit pin
  assign rx_line = !cfg_ff[USU_CFG_LOOP] ? rxd_i :
                   cfg_ff[USU_CFG_RX_SOURCE] ? txd_i : tx_line;

  // three samples around mid-bit; a disagreement marks noise
  assign rx_eval = (rx_cyc_ff == MID_CYC + 1'b1);
  assign rx_vote = (rx_samp_ff[0] & rx_samp_ff[1]) | (rx_samp_ff[1] & rx_samp_ff[2]) |
                   (rx_samp_ff[0] & rx_samp_ff[2]);
  assign rx_done = (rx_state_ff == USU_RX_STOP) && rx_eval;
  assign rx_fe = rx_done && !rx_vote; // zero where stop expected [RULE14]
  assign rx_word = cfg_ff[USU_CFG_NINE_BIT] ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
  assign rx_pe = cfg_ff[USU_CFG_PARITY_EN] && ((^rx_word) != cfg_ff[USU_CFG_PARITY_ODD]);
  // a clearing read in the same cycle frees the buffer, so nothing is lost then
  assign rx_lost = rx_done && rx_full_ff && !(rd_data && armed_ff);

  // receiver sequence; a start that votes high is a glitch and is dropped
  always_comb begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      USU_RX_IDLE: begin
        if (!rx_line) begin
          nxt_rx_state = USU_RX_START; // [RULE15]
        end
      end
      USU_RX_START: begin
        if (rx_eval) begin
          nxt_rx_state = rx_vote ? USU_RX_IDLE : USU_RX_START;
        end else if (rx_cyc_ff == LAST_CYC) begin
          nxt_rx_state = USU_RX_DATA;
        end
      end
      USU_RX_DATA: begin
        if ((rx_cyc_ff == LAST_CYC) && (rx_bits_ff == 4'h1)) begin
          nxt_rx_state = USU_RX_STOP;
        end
      end
      USU_RX_STOP: begin
        if (rx_eval) begin
          nxt_rx_state = USU_RX_IDLE; // resync early on the next start edge
        end
      end
      default: nxt_rx_state = USU_RX_IDLE;
    endcase
  end

  // receiver timing and shifting, lsb first into the top of the shifter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_ff <= USU_RX_IDLE;
      rx_cyc_ff <= '0;
      rx_bits_ff <= 4'h0;
      rx_shift_ff <= 9'h000;
      rx_samp_ff <= 3'h7;
      rx_noise_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      if (rx_state_ff == USU_RX_IDLE) begin
        rx_cyc_ff <= '0;
        rx_noise_ff <= 1'b0;
        rx_bits_ff <= cfg_ff[USU_CFG_NINE_BIT] ? 4'h9 : 4'h8; // [RULE15]
      end else begin
        rx_cyc_ff <= (rx_cyc_ff == LAST_CYC) ? '0 : rx_cyc_ff + 1'b1;
        if ((rx_cyc_ff >= MID_CYC - CW'(2)) && (rx_cyc_ff <= MID_CYC)) begin
          rx_samp_ff <= {rx_samp_ff[1:0], rx_line};
        end
        if (rx_eval) begin
          rx_noise_ff <= rx_noise_ff | (rx_samp_ff != 3'h0 && rx_samp_ff != 3'h7);
          if (rx_state_ff == USU_RX_DATA) begin
            rx_shift_ff <= {rx_vote, rx_shift_ff[8:1]}; // [RULE15]
          end
        end
        if ((rx_state_ff == USU_RX_DATA) && (rx_cyc_ff == LAST_CYC)) begin
          rx_bits_ff <= rx_bits_ff - 4'h1;
        end
      end
    end
  end

  // arm clearing on a status read that saw a receive flag set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
    end else if (rd_status) begin
      armed_ff <= rx_full_ff || (err_ff != '0);
    end else if (rd_data) begin
      armed_ff <= 1'b0;
    end
  end

  // receive buffer and flags; a new character beats the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf_ff <= USU_DATA_RST;
      rx_ninth_ff <= 1'b0;
      rx_full_ff <= 1'b0;
      err_ff <= '0;
    end else begin
      if (rd_data && armed_ff) begin
        rx_full_ff <= 1'b0; // data read finishes the sequence [RULE12]
        err_ff <= '0;
      end
      if (rx_done) begin
        if (rx_full_ff && !(rd_data && armed_ff)) begin
          err_ff.overrun <= 1'b1; // buffer still full: character lost
        end else begin
          rx_buf_ff <= rx_word[7:0];
          rx_ninth_ff <= cfg_ff[USU_CFG_NINE_BIT] & rx_word[8]; // [RULE1]
          rx_full_ff <= 1'b1;
          err_ff.noise <= rx_noise_ff;
          err_ff.framing <= rx_fe; // [RULE14]
          err_ff.parity <= rx_pe;
          err_ff.overrun <= 1'b0;
        end
      end
    end
  end

  // sticky events, cleared by reading them; a same-cycle event stays
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_ff <= 6'h00;
    end else begin
      event_ff <= (rd_event ? 6'h00 : event_ff) |
                  {tx_load, rx_done && !rx_lost,
                   rx_lost, rx_done && rx_noise_ff, rx_fe, rx_done && rx_pe};
    end
  end

  // interrupt outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      err_irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(event_ff & mask_ff);
      err_irq_ff <= (err_ff.overrun & ext_ff[USU_EXT_OVERRUN_IE]) | // [RULE7] [RULE16]
                    (err_ff.noise & ext_ff[USU_EXT_NOISE_IE]) | // [RULE8]
                    (err_ff.framing & ext_ff[USU_EXT_FRAMING_IE]) | // [RULE9]
                    (err_ff.parity & ext_ff[USU_EXT_PARITY_IE]); // [RULE10]
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign txd_o = txd_ff;
  assign txd_oe_o = txd_oe_ff;
  assign irq_o = irq_ff;
  assign err_irq_o = err_irq_ff;
endmodule // usu_regs

// *** testbench/usu_checker.sv ***
// port-level assertions for the register block
module usu_checker import usu_pkg::*; #(
  parameter int BIT_CYCLES = USU_BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic txd_i,
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic irq_o,
  input wire logic err_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] idx;
  logic win;
  logic take;
  logic wr_ok;
  logic [7:0] ext_sh_ff;
  logic [2:1] cfg_sh_ff;
  // decode of what the bus is asking for
  assign idx = wb_adr_i[11:2];
  assign win = idx[9] && idx[7:0] >= USU_OFS_STATUS && idx[7:0] <= USU_OFS_MASK;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ok = take && wb_we_i && wb_sel_i[0] && win;
  // shadow of the extended control, so readback and enables can be predicted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sh_ff <= 8'h00;
    end else if (wr_ok && idx[7:0] == USU_OFS_EXT_CTRL) begin
      ext_sh_ff <= wb_dat_i[7:0];
    end
  end
  // shadow of loop and source select only; the rest does not steer the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_sh_ff <= 2'b00;
    end else if (wr_ok && idx[7:0] == USU_OFS_CONFIG) begin
      cfg_sh_ff <= wb_dat_i[2:1];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    take;
  endsequence
  sequence s_ext_read;
    take && !wb_we_i && win && idx[7:0] == USU_OFS_EXT_CTRL;
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_idle_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside answer");
  a_unmapped_zero: assert property (s_take and !wb_we_i && !win |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ext_readback: assert property (s_ext_read |=> wb_dat_o[31:8] == 24'h00_0000
    && wb_dat_o[6:0] == $past(ext_sh_ff[6:0])) else $error("extended control readback wrong");
  a_err_masked: assert property (ext_sh_ff[3:0] == 4'h0 && $past(ext_sh_ff[3:0]) == 4'h0 |-> !err_irq_o)
    else $error("error interrupt with all enables clear");
  a_pin_dir: assert property (cfg_sh_ff == 2'b11 && $stable(cfg_sh_ff) && $stable(ext_sh_ff[5])
    |-> txd_oe_o == ext_sh_ff[5]) else $error("pin direction wrong in single wire");
  a_oe_outside: assert property (cfg_sh_ff != 2'b11 && $stable(cfg_sh_ff) |-> txd_oe_o)
    else $error("pin released outside single wire");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !err_irq_o
    && txd_o && txd_oe_o) else $error("outputs not quiet after reset");
endmodule // usu_checker

bind usu_regs usu_checker #(.BIT_CYCLES(BIT_CYCLES)) usu_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i, .txd_i, .txd_o, .txd_oe_o, .irq_o,
  .err_irq_o);

// *** testbench/usu_remote_node.sv ***
// remote serial node: sends frames on receive line, captures frames off transmit line
module usu_remote_node #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic listen_i,
  input wire logic nine_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got;
  int n_got;
  initial rxd_o = 1'b1;
  // start 0, data lsb first, chosen stop level; eight-bit mode pads with idle
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = nine_i ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // a low while listening starts a frame; mid-bit sampling; bad stop is not counted
  initial begin
    n_got = 0;
    forever begin
      @(posedge clk_i);
      if (listen_i && !line_i) begin
        got = 9'h000;
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
          repeat (BIT_CYCLES) @(posedge clk_i);
          got[i] = line_i;
        end
        repeat (BIT_CYCLES) @(posedge clk_i);
        if (line_i) n_got++;
      end
    end
  end
endmodule // usu_remote_node

// *** testbench/testbench.sv ***
// self-checking bench for the register block and its serial lines
module testbench import usu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 8;
  typedef struct {logic w; logic [9:0] idx; logic [7:0] d; logic [7:0] e;} usu_row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, inv = 1'b0, listen = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rxd, txd_i, txd_o, txd_oe_o, irq_o, err_irq_o;
  logic [7:0] q;
  int err_total = 0, cmp_count = 0, cyc_n = 0;
  usu_row_t rows [10] = '{'{0, 10'h247, 8'h00, 8'h00}, '{0, 10'h347, 8'h00, 8'h00}, '{1, 10'h246, 8'h7F, 8'h00},
    '{0, 10'h346, 8'h00, 8'h7F}, '{0, 10'h147, 8'h00, 8'h00}, '{1, 10'h146, 8'hFF, 8'h00},
    '{0, 10'h246, 8'h00, 8'h7F}, '{1, 10'h246, 8'h40, 8'h00}, '{1, 10'h245, 8'h01, 8'h00},
    '{0, 10'h245, 8'h00, 8'h01}};
  always #50 clk_i = ~clk_i;
  // transmit pin level: pulled up while the block releases it
  assign txd_i = txd_oe_o ? txd_o : 1'b1;
  usu_regs #(.BIT_CYCLES(BC)) usu_regs_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .rxd_i(rxd), .txd_i, .txd_o,
    .txd_oe_o, .irq_o, .err_irq_o);
  usu_remote_node #(.BIT_CYCLES(BC)) usu_remote_node_inst (.clk_i, .line_i(txd_o ^ inv), .listen_i(listen),
    .nine_i(1'b1), .rxd_o(rxd));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {8'h00, e}, {8'h00, g});
  endtask
  // one classic cycle, held until ack is sampled, then a cycle idle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk_byte($sformatf("reg %h", idx), {1'b0, e}, {1'b0, q});
  endtask
  task automatic tx_chk(input int n, input logic [8:0] e);
    int t;
    t = 0;
    while (usu_remote_node_inst.n_got < n && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    chk_byte("tx frame", e, usu_remote_node_inst.got);
  endtask
  task automatic rx(input logic [8:0] d, input logic stop);
    usu_remote_node_inst.send(d, stop);
    repeat (2) @(posedge clk_i); // flags land first, the error interrupt one edge later
  endtask
  // cut a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_bit("txd_o", 1'b1, txd_o);
    chk_bit("err_irq_o", 1'b0, err_irq_o);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].idx, rows[i].d);
      if (!rows[i].w) chk_byte("row", {1'b0, rows[i].e}, {1'b0, q});
    end
    // nine-bit send; ninth bit written once and reused
    listen <= 1'b1;
    wb(1'b1, 10'h247, 8'h55);
    tx_chk(1, 9'h155);
    wb(1'b1, 10'h347, 8'hAA);
    tx_chk(2, 9'h1AA);
    rdc(10'h247, 8'h00);
    // inverted line idles low; frame reads back once flipped
    listen <= 1'b0;
    wb(1'b1, 10'h246, 8'h50);
    chk_bit("txd_o", 1'b0, txd_o);
    inv <= 1'b1;
    listen <= 1'b1;
    wb(1'b1, 10'h247, 8'h3C);
    tx_chk(3, 9'h13C);
    listen <= 1'b0;
    wb(1'b1, 10'h246, 8'h40);
    inv <= 1'b0;
    // receive; event raised, masked, unmasked, cleared
    rdc(10'h248, 8'h20);
    rx(9'h1A3, 1'b1);
    chk_bit("irq_o", 1'b0, irq_o);
    wb(1'b1, 10'h249, 8'h10);
    chk_bit("irq_o", 1'b1, irq_o);
    rdc(10'h248, 8'h10);
    chk_bit("irq_o", 1'b0, irq_o);
    rdc(10'h246, 8'hC0);
    rdc(10'h244, 8'hA0);
    rdc(10'h247, 8'hA3);
    rdc(10'h244, 8'h80);
    // bad stop: polled only until its enable is set
    rx(9'h012, 1'b0);
    chk_bit("err_irq_o", 1'b0, err_irq_o);
    wb(1'b1, 10'h246, 8'h42);
    chk_bit("err_irq_o", 1'b1, err_irq_o);
    rdc(10'h244, 8'hA2);
    rdc(10'h247, 8'h12);
    chk_bit("err_irq_o", 1'b0, err_irq_o);
    // two characters unread: overrun keeps the first
    wb(1'b1, 10'h246, 8'h48);
    rx(9'h101, 1'b1);
    rx(9'h102, 1'b1);
    chk_bit("err_irq_o", 1'b1, err_irq_o);
    rdc(10'h244, 8'hA8);
    rdc(10'h247, 8'h01);
    chk_bit("err_irq_o", 1'b0, err_irq_o);
    // parity error: nine data bits, even parity enabled, odd count of ones sent
    wb(1'b1, 10'h245, 8'h09);
    wb(1'b1, 10'h246, 8'h41);
    rx(9'h001, 1'b1);
    chk_bit("err_irq_o", 1'b1, err_irq_o);
    rdc(10'h244, 8'hA1);
    rdc(10'h247, 8'h01);
    chk_bit("err_irq_o", 1'b0, err_irq_o);
    // single wire: bit 5 turns the pin around
    wb(1'b1, 10'h245, 8'h07);
    chk_bit("txd_oe_o", 1'b0, txd_oe_o);
    wb(1'b1, 10'h246, 8'h60);
    chk_bit("txd_oe_o", 1'b1, txd_oe_o);
    // reset in mid-run clears extended control and data again
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(10'h246, 8'h00);
    rdc(10'h347, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
